// ---- logic/gil_pkg.sv ----
// shared types, register map and field layout of the pin logic
package gil_pkg;

    typedef enum logic [2:0] {
        gil_mode_unused,
        gil_mode_input,
        gil_mode_output,
        gil_mode_bidir,
        gil_mode_clkout
    } gil_mode_t;

    typedef struct packed {
        gil_mode_t mode;
        logic in_reg;
        logic in_fall;
        logic in_dual;
        logic alternate_sel;
        logic out_reg;
        logic out_fall;
        logic out_dual;
        logic out_inv;
        logic oe_reg;
        logic oe_fall;
        logic unused_pull_down;
        logic diff_general;
    } gil_cfg_t;

    localparam int GIL_ADDR_W = 8;
    localparam logic [7:0] GIL_REG_CFG = 8'h00;
    localparam logic [7:0] GIL_REG_STATUS = 8'h04;

    // configuration word layout
    localparam int GIL_MODE_LSB = 0;
    localparam int GIL_IN_REG_BIT = 3;
    localparam int GIL_IN_FALL_BIT = 4;
    localparam int GIL_IN_DUAL_BIT = 5;
    localparam int GIL_ALTERNATE_SEL_BIT = 6;
    localparam int GIL_OUT_REG_BIT = 7;
    localparam int GIL_OUT_FALL_BIT = 8;
    localparam int GIL_OUT_DUAL_BIT = 9;
    localparam int GIL_OUT_INV_BIT = 10;
    localparam int GIL_OE_REG_BIT = 11;
    localparam int GIL_OE_FALL_BIT = 12;
    localparam int GIL_PULL_DOWN_BIT = 13;
    localparam int GIL_DIFF_BIT = 14;

    // status word layout
    localparam int GIL_ST_PAD_BIT = 0;
    localparam int GIL_ST_CORE_IN_BIT = 1;
    localparam int GIL_ST_CORE_FALL_BIT = 2;
    localparam int GIL_ST_OE_BIT = 3;
    localparam int GIL_ST_BUSY_BIT = 4;

    localparam gil_cfg_t GIL_CFG_RESET = '{gil_mode_unused, 1'b0, 1'b0, 1'b0, 1'b0,
        1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

    function automatic gil_cfg_t gil_unpack(input logic [31:0] w);
        gil_cfg_t c;
        c = GIL_CFG_RESET;
        case (w[GIL_MODE_LSB +: 3])
            3'h1: c.mode = gil_mode_input;
            3'h2: c.mode = gil_mode_output;
            3'h3: c.mode = gil_mode_bidir;
            3'h4: c.mode = gil_mode_clkout;
            default: c.mode = gil_mode_unused;
        endcase
        c.in_reg = w[GIL_IN_REG_BIT];
        c.in_fall = w[GIL_IN_FALL_BIT];
        c.in_dual = w[GIL_IN_DUAL_BIT];
        c.alternate_sel = w[GIL_ALTERNATE_SEL_BIT];
        c.out_reg = w[GIL_OUT_REG_BIT];
        c.out_fall = w[GIL_OUT_FALL_BIT];
        c.out_dual = w[GIL_OUT_DUAL_BIT];
        c.out_inv = w[GIL_OUT_INV_BIT];
        c.oe_reg = w[GIL_OE_REG_BIT];
        c.oe_fall = w[GIL_OE_FALL_BIT];
        c.unused_pull_down = w[GIL_PULL_DOWN_BIT];
        c.diff_general = w[GIL_DIFF_BIT];
        return c;
    endfunction : gil_unpack

    function automatic logic [31:0] gil_pack(input gil_cfg_t c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[GIL_MODE_LSB +: 3] = c.mode;
        w[GIL_IN_REG_BIT] = c.in_reg;
        w[GIL_IN_FALL_BIT] = c.in_fall;
        w[GIL_IN_DUAL_BIT] = c.in_dual;
        w[GIL_ALTERNATE_SEL_BIT] = c.alternate_sel;
        w[GIL_OUT_REG_BIT] = c.out_reg;
        w[GIL_OUT_FALL_BIT] = c.out_fall;
        w[GIL_OUT_DUAL_BIT] = c.out_dual;
        w[GIL_OUT_INV_BIT] = c.out_inv;
        w[GIL_OE_REG_BIT] = c.oe_reg;
        w[GIL_OE_FALL_BIT] = c.oe_fall;
        w[GIL_PULL_DOWN_BIT] = c.unused_pull_down;
        w[GIL_DIFF_BIT] = c.diff_general;
        return w;
    endfunction : gil_pack

endpackage : gil_pkg

// ---- logic/gil_cfg_if.sv ----
// configuration bundle passed from the pin top to its data paths
`timescale 1ns/10ps
`default_nettype none
interface gil_cfg_if;
    import gil_pkg::*;
    gil_cfg_t cfg;
    logic busy;
    modport ctl (output cfg, output busy);
    modport path (input cfg, input busy);
endinterface : gil_cfg_if
`default_nettype wire

// ---- logic/gil_in_path.sv ----
// receive path: capture registers and alternate input
`timescale 1ns/10ps
`default_nettype none
module gil_in_path
    import gil_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    gil_cfg_if.path cfg_if,
    input wire logic pad_in,
    input wire logic in_register_clock,
    output logic core_in,
    output logic core_in_fall,
    output logic alternate_out
);

    typedef struct packed {
        logic clk_prev;
        logic cap_rise;
        logic cap_fall;
    } gil_in_state_t;

    gil_in_state_t s;
    gil_in_state_t next_s;
    logic rx_en;
    logic rise;
    logic fall;

    assign rx_en = (cfg_if.cfg.mode == gil_mode_input) || (cfg_if.cfg.mode == gil_mode_bidir);
    assign rise = in_register_clock && !s.clk_prev;
    assign fall = !in_register_clock && s.clk_prev;

    // =========================================
    // capture
    always_comb begin
        next_s = s;
        next_s.clk_prev = in_register_clock;
        if (rx_en && cfg_if.cfg.in_dual) begin
            if (rise) begin
                next_s.cap_rise = pad_in;
            end
            if (fall) begin
                next_s.cap_fall = pad_in;
            end
        end else if (rx_en && cfg_if.cfg.in_reg) begin
            if (cfg_if.cfg.in_fall ? fall : rise) begin
                next_s.cap_rise = pad_in;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // unregistered receive passes straight through, the clock is ignored
    assign core_in = rx_en && ((cfg_if.cfg.in_reg || cfg_if.cfg.in_dual) ? s.cap_rise
                                                                            : pad_in);
    assign core_in_fall = rx_en && cfg_if.cfg.in_dual && s.cap_fall;
    // no register option exists on this path
    assign alternate_out = rx_en && cfg_if.cfg.alternate_sel && pad_in;

    property p_cap_edge;
        @(posedge clk) disable iff (sys_rst)
        (rx_en && cfg_if.cfg.in_reg && !cfg_if.cfg.in_dual && !cfg_if.cfg.in_fall && rise)
        |=> (s.cap_rise == $past(pad_in));
    endproperty
    a_cap_edge: assert property (p_cap_edge) else $error("rising capture missed");

    property p_dual_fall;
        @(posedge clk) disable iff (sys_rst)
        (rx_en && cfg_if.cfg.in_dual && fall) ##1 (cfg_if.cfg.in_dual && rx_en)
        |-> (core_in_fall == $past(pad_in));
    endproperty
    a_dual_fall: assert property (p_dual_fall) else $error("falling stream wrong");

    property p_alternate;
        @(posedge clk) disable iff (sys_rst)
        (rx_en && cfg_if.cfg.alternate_sel) |-> (alternate_out == pad_in);
    endproperty
    a_alternate: assert property (p_alternate) else $error("alternate input not direct");

endmodule : gil_in_path
`default_nettype wire

// ---- logic/gil_out_path.sv ----
// transmit and output-enable path with dual-edge mux and inversion
`timescale 1ns/10ps
`default_nettype none
module gil_out_path
    import gil_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    gil_cfg_if.path cfg_if,
    input wire logic core_out,
    input wire logic core_oe,
    input wire logic out_register_clock,
    output logic pad_data,
    output logic pad_drive
);

    typedef struct packed {
        logic clk_prev;
        logic out_q;
        logic out_fall_q;
        logic oe_q;
    } gil_out_state_t;

    gil_out_state_t s;
    gil_out_state_t next_s;
    logic tx_en;
    logic rise;
    logic fall;
    logic reg_val;

    assign tx_en = (cfg_if.cfg.mode == gil_mode_output) || (cfg_if.cfg.mode == gil_mode_bidir);
    assign rise = out_register_clock && !s.clk_prev;
    assign fall = !out_register_clock && s.clk_prev;

    // =========================================
    // registers on the output clock
    always_comb begin
        next_s = s;
        next_s.clk_prev = out_register_clock;
        if (tx_en && cfg_if.cfg.out_dual) begin
            if (rise) begin
                next_s.out_q = core_out;
            end
            if (fall) begin
                next_s.out_fall_q = core_out;
            end
        end else if (tx_en && cfg_if.cfg.out_reg) begin
            if (cfg_if.cfg.out_fall ? fall : rise) begin
                next_s.out_q = core_out;
            end
        end
        // the enable register shares the output clock
        if (tx_en && cfg_if.cfg.oe_reg && (cfg_if.cfg.oe_fall ? fall : rise)) begin
            next_s.oe_q = core_oe;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // high phase shows the rising register, low phase the falling one
    assign reg_val = (cfg_if.cfg.out_dual && !out_register_clock) ? s.out_fall_q
                                                                    : s.out_q;

    always_comb begin
        pad_data = 1'b0;
        pad_drive = 1'b0;
        case (cfg_if.cfg.mode)
            gil_mode_clkout: begin
                pad_data = out_register_clock;
                pad_drive = 1'b1;
            end
            gil_mode_output, gil_mode_bidir: begin
                if (cfg_if.cfg.out_reg || cfg_if.cfg.out_dual) begin
                    pad_data = reg_val ^ cfg_if.cfg.out_inv;
                end else begin
                    pad_data = core_out;
                end
                if (cfg_if.cfg.mode == gil_mode_output) begin
                    pad_drive = 1'b1;
                end else begin
                    pad_drive = cfg_if.cfg.oe_reg ? s.oe_q : core_oe;
                end
            end
            default: begin
                pad_data = 1'b0;
                pad_drive = 1'b0;
            end
        endcase
    end

    property p_out_rise;
        @(posedge clk) disable iff (sys_rst)
        (tx_en && cfg_if.cfg.out_reg && !cfg_if.cfg.out_dual && !cfg_if.cfg.out_fall && rise)
        |=> (s.out_q == $past(core_out));
    endproperty
    a_out_rise: assert property (p_out_rise) else $error("output register missed edge");

    property p_oe_reg;
        @(posedge clk) disable iff (sys_rst)
        (tx_en && cfg_if.cfg.oe_reg && !cfg_if.cfg.oe_fall && rise)
        |=> (s.oe_q == $past(core_oe));
    endproperty
    a_oe_reg: assert property (p_oe_reg) else $error("enable register missed edge");

    property p_dual_mux;
        @(posedge clk) disable iff (sys_rst)
        (cfg_if.cfg.mode == gil_mode_output && cfg_if.cfg.out_dual && out_register_clock)
        |-> (pad_data == (s.out_q ^ cfg_if.cfg.out_inv));
    endproperty
    a_dual_mux: assert property (p_dual_mux) else $error("high phase not rising data");

    property p_out_comb;
        @(posedge clk) disable iff (sys_rst)
        (cfg_if.cfg.mode == gil_mode_output && !cfg_if.cfg.out_reg && !cfg_if.cfg.out_dual)
        |-> (pad_data == core_out) && pad_drive;
    endproperty
    a_out_comb: assert property (p_out_comb) else $error("unregistered output not direct");

    property p_invert;
        @(posedge clk) disable iff (sys_rst)
        (tx_en && cfg_if.cfg.out_reg && !cfg_if.cfg.out_dual
         && cfg_if.cfg.out_inv && !cfg_if.cfg.out_fall && rise)
        ##1 (tx_en && cfg_if.cfg.out_inv && cfg_if.cfg.out_reg && !cfg_if.cfg.out_dual)
        |-> (pad_data == !$past(core_out));
    endproperty
    a_invert: assert property (p_invert) else $error("inverted output wrong");

endmodule : gil_out_path
`default_nettype wire

// ---- logic/gil_top.sv ----
// general-purpose pin logic top: register port, pull control and pad drive
//
// Function
// - input mode enables only receive path
// - receive capture uses input clock, chosen edge
// - alternate input path is always combinational
// - dual-edge input gives rise and fall streams
// - output mode drives; register on output clock
// - registered output value can be inverted
// - dual-edge output captures on both clock edges
// - bidirectional mode enables receive, transmit, enable
// - input clock captures; output clock drives output, enable
// - receive and transmit registering chosen independently
// - enable register decides pad drive or release
// - clock-output mode forwards clock to pad
// - alternate input feeds reference clock directly
// - during configuration pins held weak pull-up; differential pins used as general pins get no pull
// - unused pins tri-stated with weak pull-up
// - unused pull-up replaceable by weak pull-down
// - core supplies enable, registered or direct
// - output clock governs output and enable registers
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module gil_top
    import gil_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    // register port
    input wire logic [GIL_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // core side
    input wire logic config_active,
    input wire logic in_register_clock,
    input wire logic out_register_clock,
    input wire logic core_out,
    input wire logic core_oe,
    output logic core_in,
    output logic core_in_fall,
    output logic alternate_input,
    // pad side
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe,
    output logic pad_pull_up,
    output logic pad_pull_down
);

    typedef struct packed {
        gil_cfg_t cfg;
        logic [31:0] rdata;
        logic pull_up;
        logic pull_down;
    } gil_top_state_t;

    gil_top_state_t s;
    gil_top_state_t next_s;
    logic pad_data;
    logic pad_drive;
    logic [31:0] status_word;

    gil_cfg_if cfg_bus ();

    assign cfg_bus.cfg = s.cfg;
    assign cfg_bus.busy = config_active;

    // =========================================
    // data paths
    // receive and transmit keep separate register choices
    gil_in_path u_in (
        .clk(clk),
        .sys_rst(sys_rst),
        .cfg_if(cfg_bus.path),
        .pad_in(pad_in),
        .in_register_clock(in_register_clock),
        .core_in(core_in),
        .core_in_fall(core_in_fall),
        .alternate_out(alternate_input)
    );

    gil_out_path u_out (
        .clk(clk),
        .sys_rst(sys_rst),
        .cfg_if(cfg_bus.path),
        .core_out(core_out),
        .core_oe(core_oe),
        .out_register_clock(out_register_clock),
        .pad_data(pad_data),
        .pad_drive(pad_drive)
    );

    // =========================================
    // status
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[GIL_ST_PAD_BIT] = pad_in;
        status_word[GIL_ST_CORE_IN_BIT] = core_in;
        status_word[GIL_ST_CORE_FALL_BIT] = core_in_fall;
        status_word[GIL_ST_OE_BIT] = pad_oe;
        status_word[GIL_ST_BUSY_BIT] = config_active;
    end

    // =========================================
    // registers and pulls
    always_comb begin
        next_s = s;
        next_s.rdata = 32'h0000_0000;
        if (reg_write) begin
            if (reg_addr == GIL_REG_CFG) begin
                next_s.cfg = gil_unpack(reg_wdata);
            end
        end
        if (reg_read) begin
            if (reg_addr == GIL_REG_CFG) begin
                next_s.rdata = gil_pack(s.cfg);
            end else if (reg_addr == GIL_REG_STATUS) begin
                next_s.rdata = status_word;
            end else begin
                next_s.rdata = 32'h0000_0000;
            end
        end
        // differential pins used as general pins get no pull while configuring
        if (config_active) begin
            next_s.pull_up = !s.cfg.diff_general;
            next_s.pull_down = 1'b0;
        end else if (s.cfg.mode == gil_mode_unused) begin
            next_s.pull_up = !s.cfg.unused_pull_down;
            next_s.pull_down = s.cfg.unused_pull_down;
        end else begin
            next_s.pull_up = 1'b0;
            next_s.pull_down = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s <= '{GIL_CFG_RESET, 32'h0000_0000, 1'b1, 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata = s.rdata;
    assign pad_pull_up = s.pull_up;
    assign pad_pull_down = s.pull_down;
    // pad data and drive stay combinational so unregistered paths add no delay
    assign pad_out = pad_data;
    assign pad_oe = pad_drive && !config_active;

    // =========================================
    // checks
    property p_cfg_pull;
        @(posedge clk) disable iff (sys_rst)
        (config_active && !s.cfg.diff_general) |-> !pad_oe ##1 (pad_pull_up && !pad_pull_down);
    endproperty
    a_cfg_pull: assert property (p_cfg_pull) else $error("no pull-up while configuring");

    property p_unused_tristate;
        @(posedge clk) disable iff (sys_rst)
        (s.cfg.mode == gil_mode_unused) |-> !pad_oe;
    endproperty
    a_unused_tristate: assert property (p_unused_tristate) else $error("unused pin driven");

    property p_unused_pull;
        @(posedge clk) disable iff (sys_rst)
        (!config_active && s.cfg.mode == gil_mode_unused)
        |=> (pad_pull_down == $past(s.cfg.unused_pull_down))
            && (pad_pull_up == !$past(s.cfg.unused_pull_down));
    endproperty
    a_unused_pull: assert property (p_unused_pull) else $error("unused pull wrong");

    property p_input_rx_only;
        @(posedge clk) disable iff (sys_rst)
        (s.cfg.mode == gil_mode_input) |-> !pad_oe;
    endproperty
    a_input_rx_only: assert property (p_input_rx_only) else $error("input pin driven");

    property p_clkout;
        @(posedge clk) disable iff (sys_rst)
        (s.cfg.mode == gil_mode_clkout && !config_active)
        |-> (pad_out == out_register_clock) && pad_oe;
    endproperty
    a_clkout: assert property (p_clkout) else $error("clock not forwarded");

    property p_read_data;
        @(posedge clk) disable iff (sys_rst)
        (reg_read && reg_addr == GIL_REG_CFG) |=> (reg_rdata == gil_pack($past(s.cfg)));
    endproperty
    a_read_data: assert property (p_read_data) else $error("config readback wrong");

endmodule : gil_top
`default_nettype wire

// ---- tb/gil_core_model.sv ----
// far-side model: core register clocks and the pad wire with its pulls
`timescale 1ns/10ps
`default_nettype none
module gil_core_model (
    input wire logic clk,
    input wire logic pad_out,
    input wire logic pad_oe,
    input wire logic pad_pull_up,
    input wire logic pad_pull_down,
    input wire logic ext_drv,
    input wire logic ext_val,
    output logic pad_in,
    output logic in_register_clock,
    output logic out_register_clock
);
    // =====================================================
    // register clocks: stand still until a step is asked for
    initial begin
        in_register_clock = 1'b0;
        out_register_clock = 1'b0;
    end

    // the pin logic samples these clocks, so each level is held several cycles
    task automatic edge_in();
        @(posedge clk);
        in_register_clock <= ~in_register_clock;
        repeat (4) @(posedge clk);
        #1;
    endtask : edge_in

    task automatic edge_out();
        @(posedge clk);
        out_register_clock <= ~out_register_clock;
        repeat (4) @(posedge clk);
        #1;
    endtask : edge_out

    // =====================================================
    // pad wire
    // a released wire with no pull shows the inverse of the last data offered
    assign pad_in = pad_oe ? pad_out : ext_drv ? ext_val :
        pad_pull_up ? 1'b1 : pad_pull_down ? 1'b0 : ~pad_out;
endmodule : gil_core_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking testbench for the pin logic
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import gil_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [GIL_ADDR_W-1:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [31:0] reg_rdata;
    logic config_active = 1'b0;
    logic core_out = 1'b0;
    logic core_oe = 1'b0;
    logic ext_drv = 1'b0;
    logic ext_val = 1'b0;
    logic in_register_clock;
    logic out_register_clock;
    logic core_in;
    logic core_in_fall;
    logic alternate_input;
    logic pad_in;
    logic pad_out;
    logic pad_oe;
    logic pad_pull_up;
    logic pad_pull_down;
    int failures = 0;
    int total_checks = 0;

    always #5 clk = ~clk;

    gil_top dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .config_active(config_active),
        .in_register_clock(in_register_clock), .out_register_clock(out_register_clock),
        .core_out(core_out), .core_oe(core_oe), .core_in(core_in),
        .core_in_fall(core_in_fall), .alternate_input(alternate_input),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down));

    gil_core_model far (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down),
        .ext_drv(ext_drv), .ext_val(ext_val), .pad_in(pad_in),
        .in_register_clock(in_register_clock), .out_register_clock(out_register_clock));

    // =====================================================
    // helpers
    function automatic logic [31:0] b(input int n);
        return 32'h1 << n;
    endfunction : b

    function automatic logic [31:0] cw(input logic [2:0] m, input logic [31:0] f);
        return {29'h0, m} | f;
    endfunction : cw

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask : wr

    // read data stand in the cycle after the strobe and only there
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        chk(nm, exp, reg_rdata);
        @(posedge clk);
        #1;
        chk(nm, 32'h0, reg_rdata);
    endtask : rd

    task automatic print_verdict();
        if (failures == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict

    initial begin
        #100000;
        failures++;
        print_verdict();
    end

    // =====================================================
    // scenarios
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1;
        chk("pad_oe", 32'h0, pad_oe);
        chk("pull_up", 32'h1, pad_pull_up);
        chk("pull_down", 32'h0, pad_pull_down);
        rd(GIL_REG_CFG, 32'h0, "config");
        rd(8'h08, 32'h0, "unmapped");
        wr(GIL_REG_CFG, 32'hffff_fffb);
        rd(GIL_REG_CFG, 32'h0000_7ffb, "config");
        wr(GIL_REG_CFG, b(GIL_PULL_DOWN_BIT));
        chk("pull_up", 32'h0, pad_pull_up);
        chk("pull_down", 32'h1, pad_pull_down);
        wr(GIL_REG_STATUS, 32'hffff_ffff);
        rd(GIL_REG_CFG, b(GIL_PULL_DOWN_BIT), "config");
        // configuring: output pin still released and pulled up
        @(posedge clk);
        config_active <= 1'b1;
        wr(GIL_REG_CFG, cw(3'h2, 32'h0));
        chk("pad_oe", 32'h0, pad_oe);
        chk("pull_up", 32'h1, pad_pull_up);
        wr(GIL_REG_CFG, cw(3'h2, b(GIL_DIFF_BIT)));
        chk("pull_up", 32'h0, pad_pull_up);
        @(posedge clk);
        config_active <= 1'b0;
        // unregistered input and alternate path
        wr(GIL_REG_CFG, cw(3'h1, b(GIL_ALTERNATE_SEL_BIT)));
        for (int v = 0; v < 2; v++) begin
            @(posedge clk);
            ext_drv <= 1'b1;
            ext_val <= v[0];
            #1;
            chk("core_in", 32'(v[0]), core_in);
            chk("alternate_input", 32'(v[0]), alternate_input);
            chk("pad_oe", 32'h0, pad_oe);
        end
        // registered input, rising then falling edge
        wr(GIL_REG_CFG, cw(3'h1, b(GIL_IN_REG_BIT)));
        far.edge_in();
        chk("core_in", 32'h1, core_in);
        @(posedge clk);
        ext_val <= 1'b0;
        far.edge_in();
        chk("core_in", 32'h1, core_in);
        wr(GIL_REG_CFG, cw(3'h1, b(GIL_IN_REG_BIT) | b(GIL_IN_FALL_BIT)));
        far.edge_in();
        chk("core_in", 32'h1, core_in);
        far.edge_in();
        chk("core_in", 32'h0, core_in);
        // dual-edge input: rise sample 0, fall sample 1
        wr(GIL_REG_CFG, cw(3'h1, b(GIL_IN_REG_BIT) | b(GIL_IN_DUAL_BIT)));
        far.edge_in();
        @(posedge clk);
        ext_val <= 1'b1;
        far.edge_in();
        chk("core_in", 32'h0, core_in);
        chk("core_in_fall", 32'h1, core_in_fall);
        rd(GIL_REG_STATUS, 32'h5, "status");
        @(posedge clk);
        ext_drv <= 1'b0;
        core_out <= 1'b1;
        // registered inverted output on rising edge only
        wr(GIL_REG_CFG, cw(3'h2, b(GIL_OUT_REG_BIT) | b(GIL_OUT_INV_BIT)));
        far.edge_out();
        chk("pad_out", 32'h0, pad_out);
        chk("pad_oe", 32'h1, pad_oe);
        @(posedge clk);
        core_out <= 1'b0;
        far.edge_out();
        chk("pad_out", 32'h0, pad_out);
        // falling-edge output register: rise keeps old value, fall takes core data
        wr(GIL_REG_CFG, cw(3'h2, b(GIL_OUT_REG_BIT) | b(GIL_OUT_FALL_BIT)));
        far.edge_out();
        chk("pad_out", 32'h1, pad_out);
        far.edge_out();
        chk("pad_out", 32'h0, pad_out);
        wr(GIL_REG_CFG, cw(3'h2, 32'h0));
        for (int v = 0; v < 2; v++) begin
            @(posedge clk);
            core_out <= v[0];
            #1;
            chk("pad_out", 32'(v[0]), pad_out);
        end
        // dual-edge output: high phase rise register, low phase fall register
        wr(GIL_REG_CFG, cw(3'h2, b(GIL_OUT_REG_BIT) | b(GIL_OUT_DUAL_BIT)));
        far.edge_out();
        chk("pad_out", 32'h1, pad_out);
        @(posedge clk);
        core_out <= 1'b0;
        far.edge_out();
        chk("pad_out", 32'h0, pad_out);
        // bidirectional: registered enable and input, direct output
        wr(GIL_REG_CFG, cw(3'h3, b(GIL_OE_REG_BIT) | b(GIL_IN_REG_BIT)));
        @(posedge clk);
        core_oe <= 1'b1;
        core_out <= 1'b1;
        #1;
        chk("pad_oe", 32'h0, pad_oe);
        chk("pad_out", 32'h1, pad_out);
        far.edge_out();
        chk("pad_oe", 32'h1, pad_oe);
        far.edge_in();
        chk("core_in", 32'h1, core_in);
        @(posedge clk);
        core_oe <= 1'b0;
        far.edge_in();
        chk("pad_oe", 32'h1, pad_oe);
        far.edge_out();
        chk("pad_oe", 32'h1, pad_oe);
        far.edge_out();
        chk("pad_oe", 32'h0, pad_oe);
        wr(GIL_REG_CFG, cw(3'h3, 32'h0));
        for (int v = 1; v >= 0; v--) begin
            @(posedge clk);
            core_oe <= v[0];
            #1;
            chk("pad_oe", 32'(v[0]), pad_oe);
        end
        // clock forwarding
        wr(GIL_REG_CFG, cw(3'h4, 32'h0));
        chk("pad_oe", 32'h1, pad_oe);
        far.edge_out();
        chk("pad_out", 32'h0, pad_out);
        far.edge_out();
        chk("pad_out", 32'h1, pad_out);
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
